//--- src/idb_pkg.sv
// Purpose: shared constants and types for the isolated bitstream output block
// Assumes: reference clock of 20 MHz drives all logic
// Notes:   times are kept in their own unit and turned into cycle counts here
package idb_pkg;

  // reference clock
  localparam int REF_CLK_HZ       = 20_000_000;
  localparam int REF_PERIOD_NS    = 1_000_000_000 / REF_CLK_HZ;

  // modulator clock choices for the internally clocked build, and the external clock maximum
  localparam int MOD_CLK_10M_HZ   = 10_000_000;
  localparam int MOD_CLK_20M_HZ   = 20_000_000;
  localparam int MOD_CLK_EXT_MAX_HZ = 25_000_000;

  // supply recovery wait, least time so rounded up
  localparam int RECOVER_US       = 250;
  localparam int RECOVER_CYCLES   = (RECOVER_US * 1000 + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
  localparam int RECOVER_CNT_W    = 16;

  // clock cycles still driven after input-side supply loss
  localparam int STOP_CYCLES      = 256;
  localparam int STOP_CNT_W       = 9;

  // run length whose last equal bit is forced to the opposite value
  localparam int RUN_LIMIT_BITS   = 128;
  localparam int RUN_MAX          = RUN_LIMIT_BITS - 1;
  localparam int RUN_CNT_W        = 7;

  // input scaling: full scale maps to 25/32 of the feedback level,
  // giving 89.06 % / 10.94 % ones at +/- full scale
  localparam int GAIN_NUM         = 25;
  localparam int GAIN_SHIFT       = 5;

  // input code and accumulator widths and specified full scale code
  localparam int IN_W             = 16;
  localparam int ACC_W            = 24;
  localparam int FULL_SCALE_CODE  = 16384;

  // reset values
  localparam logic RST_MOD_CLK    = 1'b0;

  // link phases
  typedef enum logic [1:0] {
    IDB_RUN,
    IDB_LOST_RUN,
    IDB_LOST_STOP,
    IDB_RECOVER
  } idb_phase_t;

endpackage

//--- src/idb_modulator.sv
// Purpose: second-order delta-sigma loop producing one bit per step
// Assumes: input codes come from logic on i_ref_clk, no synchroniser needed
// Notes:   feedback uses the bit actually emitted, so forced bits stay in the loop
`timescale 1ns/100ps
module idb_modulator #(
  parameter int IN_W       = idb_pkg::IN_W,
  parameter int ACC_W      = idb_pkg::ACC_W,
  parameter int FULL_SCALE = idb_pkg::FULL_SCALE_CODE
) (
  // clock and reset
  input  wire logic              i_ref_clk,
  input  wire logic              i_reset,
  // loop control
  input  wire logic              i_clear,
  input  wire logic              i_step,
  input  wire logic              i_fb_bit,
  // differential input codes
  input  wire logic [IN_W-1:0]   i_analog_positive_input,
  input  wire logic [IN_W-1:0]   i_analog_negative_input,
  // candidate bit for the next step
  output logic                   o_bit
);

  typedef struct packed {
    logic signed [ACC_W-1:0] integ1;
    logic signed [ACC_W-1:0] integ2;
  } idb_mod_state_t;

  idb_mod_state_t q;
  idb_mod_state_t d;
  logic signed [ACC_W-1:0] diff;
  logic signed [ACC_W-1:0] u;
  logic signed [ACC_W-1:0] fb;
  logic signed [ACC_W-1:0] fs;

  ////////////////////////////////////////////////////////////////////////////
  // comparator on the second integrator
  assign o_bit = ~q.integ2[ACC_W-1];

  ////////////////////////////////////////////////////////////////////////////
  // loop update, half-weight integrators keep it stable up to the clip level
  always_comb
  begin
    d    = q;
    fs   = ACC_W'(FULL_SCALE);
    diff = ACC_W'($signed(i_analog_positive_input)) - ACC_W'($signed(i_analog_negative_input));
    // clip beyond full scale, the loop would lose stability above it
    if (diff > fs)
    begin
      diff = fs;
    end
    else if (diff < -fs)
    begin
      diff = -fs;
    end
    u  = (diff * ACC_W'(idb_pkg::GAIN_NUM)) >>> idb_pkg::GAIN_SHIFT;
    fb = i_fb_bit ? fs : -fs;
    if (i_clear)
    begin
      d.integ1 = '0;
      d.integ2 = '0;
    end
    else if (i_step)
    begin
      d.integ1 = q.integ1 + ((u - fb) >>> 1);
      d.integ2 = q.integ2 + ((q.integ1 - fb) >>> 1);
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

endmodule

//--- src/idb_top.sv
// Purpose: digital output side of an isolated delta-sigma modulator
// Assumes: supply-good and external clock arrive from pins and are synchronised
// Notes:   20 MHz driven clock needs a faster reference than the 20 MHz one here
`timescale 1ns/100ps
module idb_top #(
  parameter bit INTERNAL_CLK   = 1'b1,
  parameter int MOD_CLK_HZ     = idb_pkg::MOD_CLK_10M_HZ,
  parameter int RECOVER_CYCLES = idb_pkg::RECOVER_CYCLES,
  parameter int IN_W           = idb_pkg::IN_W
) (
  // clock and reset
  input  wire logic            i_ref_clk,
  input  wire logic            i_reset,
  // pins from the input side and the filter side
  input  wire logic            i_input_side_supply,
  input  wire logic            i_ext_mod_clk,
  // differential input codes
  input  wire logic [IN_W-1:0] i_analog_positive_input,
  input  wire logic [IN_W-1:0] i_analog_negative_input,
  // bitstream and clock pins
  output logic                 o_modulator_bitstream_out,
  output logic                 o_mod_clk,
  output logic                 o_mod_clk_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // phase walk of the block
  //
  // run:
  //   one bit is launched on every falling modulator clock edge
  //   the loop steps only on that same edge, so bits and steps pair one to one
  //   a supply drop, once seen through the two sync flops, leaves at once
  //
  // lost_run:
  //   data is forced to the fail-safe level from the next edge
  //   internal build: the divider keeps running and rising edges are counted
  //   external build: nothing to count, the pin clock belongs to the far side
  //   a supply return here skips the stop and goes straight to recovery
  //
  // lost_stop:
  //   internal build: the divider is frozen right after a rising edge,
  //   so the driven clock rests high and the far side sees no more edges
  //   data keeps the fail-safe level, loop integrators are held cleared
  //
  // recover:
  //   the clock is running again, data still holds the fail-safe level
  //   the wait counter covers the settling time of the restarted input side
  //   a new drop here restarts the whole run-out count from zero
  //   reset also lands here, so a fresh start looks like a supply return
  //
  // hazards and limits:
  //   the supply pin is sampled, so drops shorter than one reference cycle
  //   may pass unseen; the analog side cannot glitch that fast in practice
  //   the external clock is found by edge detect on the reference clock,
  //   so its low phase must span more than one reference cycle
  //   a driven clock faster than half the reference rate cannot be made;
  //   the divider floors the half period at one reference cycle
  //   the forced opposite bit of the run limit goes back into the loop,
  //   trading a tiny burst of noise for a mean that still tracks the input
  ////////////////////////////////////////////////////////////////////////////

  // divider sizing from the reference and the chosen driven clock
  localparam int  HALF_RAW  = idb_pkg::REF_CLK_HZ / (2 * MOD_CLK_HZ);
  localparam int  HALF_CYC  = (HALF_RAW < 1) ? 1 : HALF_RAW;
  localparam int  DIV_W     = (HALF_CYC < 2) ? 1 : $clog2(HALF_CYC);
  localparam logic FAILSAFE = INTERNAL_CLK ? 1'b1 : 1'b0;

  typedef struct packed {
    logic                                supply_s1;
    logic                                supply_s2;
    logic                                clk_s1;
    logic                                clk_s2;
    logic                                clk_s3;
    idb_pkg::idb_phase_t                 phase;
    logic [DIV_W-1:0]                    div_cnt;
    logic                                mod_clk;
    logic                                clk_oe;
    logic [idb_pkg::STOP_CNT_W-1:0]      stop_cnt;
    logic [idb_pkg::RECOVER_CNT_W-1:0]   rec_cnt;
    logic [idb_pkg::RUN_CNT_W-1:0]       run_cnt;
    logic                                last_bit;
    logic                                data;
  } idb_top_state_t;

  // registered state and its next value, one copy each
  idb_top_state_t q;
  idb_top_state_t d;
  // loop handshake and edge strobes, all combinational
  logic           cand_bit;
  logic           emit_bit;
  logic           step;
  logic           dsm_clear;
  logic           launch;
  logic           rise;
  logic           supply_ok;

  ////////////////////////////////////////////////////////////////////////////
  // loop instance, stepped once per launched bit
  idb_modulator #(
    .IN_W       (IN_W),
    .ACC_W      (idb_pkg::ACC_W),
    .FULL_SCALE (idb_pkg::FULL_SCALE_CODE)
  ) u_modulator (
    .i_ref_clk               (i_ref_clk),
    .i_reset                 (i_reset),
    .i_clear                 (dsm_clear),
    .i_step                  (step),
    .i_fb_bit                (emit_bit),
    .i_analog_positive_input (i_analog_positive_input),
    .i_analog_negative_input (i_analog_negative_input),
    .o_bit                   (cand_bit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb
  begin
    d         = q;
    step      = 1'b0;
    dsm_clear = 1'b0;
    launch    = 1'b0;
    rise      = 1'b0;
    emit_bit  = 1'b0;
    // supply pin passes two flops, clock pin three; edge detect looks only at the second and third
    d.supply_s1 = i_input_side_supply;
    d.supply_s2 = q.supply_s1;
    d.clk_s1    = i_ext_mod_clk;
    d.clk_s2    = q.clk_s1;
    d.clk_s3    = q.clk_s2;
    supply_ok   = q.supply_s2;

    // clock source: divider driven out, or falling edge of the pin clock
    if (INTERNAL_CLK)
    begin
      d.clk_oe = 1'b1;
      if (q.phase != idb_pkg::IDB_LOST_STOP)
      begin
        if (q.div_cnt == DIV_W'(HALF_CYC - 1))
        begin
          d.div_cnt = '0;
          d.mod_clk = ~q.mod_clk;
          launch    = q.mod_clk;
          rise      = ~q.mod_clk;
        end
        else
        begin
          d.div_cnt = q.div_cnt + DIV_W'(1);
        end
      end
    end
    else
    begin
      d.clk_oe  = 1'b0;
      d.mod_clk = 1'b0;
      launch    = ~q.clk_s2 & q.clk_s3;
    end

    // run-length limit keeps full scale apart from the fail-safe level
    // the counter never passes RUN_MAX: the bit after a count of RUN_MAX always differs and restarts it
    // at one, so the longest run of equal bits seen outside is RUN_MAX, 127 bits, one below the limit
    emit_bit = cand_bit;
    if ((q.run_cnt == idb_pkg::RUN_CNT_W'(idb_pkg::RUN_MAX)) && (cand_bit == q.last_bit))
    begin
      emit_bit = ~q.last_bit;
    end

    unique case (q.phase)
      idb_pkg::IDB_RUN:
      begin
        if (!supply_ok)
        begin
          d.phase    = idb_pkg::IDB_LOST_RUN;
          d.stop_cnt = '0;
          d.data     = FAILSAFE;
        end
        else if (launch)
        begin
          // one new bit per falling clock edge
          step       = 1'b1;
          d.data     = emit_bit;
          d.last_bit = emit_bit;
          if (emit_bit == q.last_bit)
          begin
            d.run_cnt = q.run_cnt + idb_pkg::RUN_CNT_W'(1);
          end
          else
          begin
            d.run_cnt = idb_pkg::RUN_CNT_W'(1);
          end
        end
      end
      idb_pkg::IDB_LOST_RUN:
      begin
        d.data    = FAILSAFE;
        dsm_clear = 1'b1;
        if (supply_ok)
        begin
          d.phase   = idb_pkg::IDB_RECOVER;
          d.rec_cnt = '0;
        end
        else if (!INTERNAL_CLK)
        begin
          d.phase = idb_pkg::IDB_LOST_STOP;
        end
        else if (rise)
        begin
          // stop right after the last rising edge so the clock rests high
          d.stop_cnt = q.stop_cnt + idb_pkg::STOP_CNT_W'(1);
          if (q.stop_cnt == idb_pkg::STOP_CNT_W'(idb_pkg::STOP_CYCLES - 1))
          begin
            d.phase = idb_pkg::IDB_LOST_STOP;
          end
        end
      end
      idb_pkg::IDB_LOST_STOP:
      begin
        d.data    = FAILSAFE;
        dsm_clear = 1'b1;
        if (supply_ok)
        begin
          d.phase   = idb_pkg::IDB_RECOVER;
          d.rec_cnt = '0;
        end
      end
      idb_pkg::IDB_RECOVER:
      begin
        // clock already runs again, data holds fail-safe during the wait
        d.data     = FAILSAFE;
        dsm_clear  = 1'b1;
        d.run_cnt  = '0;
        d.last_bit = FAILSAFE;
        if (!supply_ok)
        begin
          d.phase    = idb_pkg::IDB_LOST_RUN;
          d.stop_cnt = '0;
        end
        else if (q.rec_cnt == idb_pkg::RECOVER_CNT_W'(RECOVER_CYCLES - 1))
        begin
          d.phase = idb_pkg::IDB_RUN;
        end
        else
        begin
          d.rec_cnt = q.rec_cnt + idb_pkg::RECOVER_CNT_W'(1);
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register, reset behaves like a fresh supply-up
  // the sync flops clear to zero, so the first edges after reset read the
  // supply as lost; the block then falls through lost_run, and in the external build lost_stop, back into recover
  // and the recovery wait starts once the pin has been seen good
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      q          <= '0;
      q.phase    <= idb_pkg::IDB_RECOVER;
      q.mod_clk  <= idb_pkg::RST_MOD_CLK;
      q.data     <= FAILSAFE;
      q.last_bit <= FAILSAFE;
    end
    else
    begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from flops
  assign o_modulator_bitstream_out = q.data;
  assign o_mod_clk                 = q.mod_clk;
  assign o_mod_clk_oe              = q.clk_oe;

endmodule

//--- testbench/idb_top_asserts.sv
// Purpose: pin checks for the bitstream output block
// Assumes: 10 MHz driven clock, 400 ns external clock
// Notes:   up marks a settled run after recovery
`timescale 1ns/100ps
module idb_top_asserts #(
  parameter bit INTERNAL_CLK   = 1'b1,
  parameter int RECOVER_CYCLES = 20,
  parameter int IN_W           = 16
) (
  // inputs
  input wire logic            i_ref_clk,
  input wire logic            i_reset,
  input wire logic            i_input_side_supply,
  input wire logic            i_ext_mod_clk,
  input wire logic [IN_W-1:0] i_analog_positive_input,
  input wire logic [IN_W-1:0] i_analog_negative_input,
  // outputs
  input wire logic            o_modulator_bitstream_out,
  input wire logic            o_mod_clk,
  input wire logic            o_mod_clk_oe
);
  localparam int LIM = INTERNAL_CLK ? 254 : 1016;
  logic [15:0] up_q;
  logic [15:0] lost_q;
  logic [15:0] run_q;
  logic        up;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  ////////////////////////////////////////
  // supply good, supply lost and equal-bit counters
  assign up = up_q > 16'(RECOVER_CYCLES + 16);
  always_ff @(posedge i_ref_clk)
  begin
    up_q   <= (i_reset || !i_input_side_supply) ? '0 : up_q + {15'h0, ~&up_q};
    lost_q <= (i_reset || i_input_side_supply) ? '0 : lost_q + {15'h0, ~&lost_q};
    run_q  <= (!up || $changed(o_modulator_bitstream_out)) ? 16'h1 : run_q + 16'h1;
  end
  ////////////////////////////////////////
  a_run_limit: assert property (run_q <= 16'(LIM))
    else $error("run of equal bits too long");
  a_data_on_fall: assert property (INTERNAL_CLK && up && $changed(o_modulator_bitstream_out) |-> $fell(o_mod_clk))
    else $error("bit changed off the clock fall");
  a_ext_data_lag: assert property (!INTERNAL_CLK && up && $changed(o_modulator_bitstream_out)
    |-> ($past(i_ext_mod_clk, 4) && !$past(i_ext_mod_clk, 3)) || ($past(i_ext_mod_clk, 5) && !$past(i_ext_mod_clk, 4)))
    else $error("bit changed off the external fall");
  a_clk_toggles: assert property (INTERNAL_CLK && up |=> $changed(o_mod_clk))
    else $error("driven clock not at half reference rate");
  a_fail_level: assert property (!i_input_side_supply [*6] |-> o_modulator_bitstream_out == INTERNAL_CLK)
    else $error("wrong fail-safe level");
  a_clk_runout: assert property (INTERNAL_CLK && lost_q > 16'd8 && lost_q < 16'd505 |=> $changed(o_mod_clk))
    else $error("clock stopped early after loss");
  a_clk_rests: assert property (INTERNAL_CLK && lost_q > 16'd520 |-> o_mod_clk)
    else $error("clock not resting high");
  a_recover_hold: assert property (i_input_side_supply && up_q < 16'(RECOVER_CYCLES)
    |-> o_modulator_bitstream_out == INTERNAL_CLK)
    else $error("data resumed too early");
  a_oe_level: assert property (!i_reset [*3] |-> o_mod_clk_oe == INTERNAL_CLK)
    else $error("clock pin enable wrong");
endmodule
bind idb_top idb_top_asserts #(
  .INTERNAL_CLK(INTERNAL_CLK), .RECOVER_CYCLES(RECOVER_CYCLES), .IN_W(IN_W)
) u_idb_top_asserts (
  .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_input_side_supply(i_input_side_supply),
  .i_ext_mod_clk(i_ext_mod_clk), .i_analog_positive_input(i_analog_positive_input),
  .i_analog_negative_input(i_analog_negative_input), .o_modulator_bitstream_out(o_modulator_bitstream_out),
  .o_mod_clk(o_mod_clk), .o_mod_clk_oe(o_mod_clk_oe)
);

//--- testbench/idb_filter_model.sv
// Purpose: filter side model, supplies a clock and counts ones
// Assumes: one clock feeds both modulator and counter
// Notes:   clock stands low while i_run is low
`timescale 1ns/100ps
module idb_filter_model (
  // control and stream
  input  wire logic   i_run,
  input  wire logic   i_clr,
  input  wire logic   i_mod_clk,
  input  wire logic   i_bit,
  // clock and counts
  output logic        o_clk,
  output logic [15:0] o_ones,
  output logic [15:0] o_bits
);
  // 400 ns clock, odd phase so no edge meets the reference
  initial
  begin
    o_clk = 1'b0;
    #37;
    forever #200 o_clk = i_run ? ~o_clk : 1'b0;
  end
  // decimation reduced to a ones count, one bit a rising edge
  always @(posedge i_mod_clk or posedge i_clr)
    if (i_clr)
    begin
      o_ones <= '0;
      o_bits <= '0;
    end
    else
    begin
      o_ones <= o_ones + {15'h0, i_bit};
      o_bits <= o_bits + 16'h1;
    end
endmodule

//--- testbench/isolated_dsm_bitstream_output_test.sv
// Purpose: self-checking bench for the bitstream output block
// Assumes: 20 MHz reference, 400 ns external modulator clock
// Notes:   both builds run side by side on one supply and input
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; $display("ERROR %0t got %0d", $time, g); end end
module isolated_dsm_bitstream_output_test;
  localparam int RC = 20;
  logic        clk = 1'b0, rst = 1'b1, sup = 1'b1, run = 1'b0, clr = 1'b0;
  logic [15:0] pos = '0, neg = '0, on_i, bt_i, on_e, bt_e;
  logic        dat_i, mck_i, oe_i, dat_e, mck_e, oe_e, xclk;
  logic [31:0] r = 32'h1c311e34;
  int          num_errors = 0, n_checks = 0, w = 0;
  int          lv[5] = '{16384, 8192, 0, -8192, -16384};
  always #25 clk = ~clk;
  ////////////////////////////////////////
  idb_top #(.INTERNAL_CLK(1'b1), .RECOVER_CYCLES(RC)) u_idb_top (
    .i_ref_clk(clk), .i_reset(rst), .i_input_side_supply(sup), .i_ext_mod_clk(1'b0),
    .i_analog_positive_input(pos), .i_analog_negative_input(neg),
    .o_modulator_bitstream_out(dat_i), .o_mod_clk(mck_i), .o_mod_clk_oe(oe_i));
  idb_top #(.INTERNAL_CLK(1'b0), .RECOVER_CYCLES(RC)) u_idb_top_ext (
    .i_ref_clk(clk), .i_reset(rst), .i_input_side_supply(sup), .i_ext_mod_clk(xclk),
    .i_analog_positive_input(pos), .i_analog_negative_input(neg),
    .o_modulator_bitstream_out(dat_e), .o_mod_clk(mck_e), .o_mod_clk_oe(oe_e));
  idb_filter_model u_idb_filter_model (.i_run(1'b0), .i_clr(clr), .i_mod_clk(mck_i),
    .i_bit(dat_i), .o_clk(), .o_ones(on_i), .o_bits(bt_i));
  idb_filter_model u_idb_filter_model_ext (.i_run(run), .i_clr(clr), .i_mod_clk(xclk),
    .i_bit(dat_e), .o_clk(xclk), .o_ones(on_e), .o_bits(bt_e));
  ////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // ones of n bits must sit near n * (1/2 + 25/64 * d / 16384)
  function automatic logic near(input logic [15:0] on, input int n, input int d);
    int ex;
    ex = n / 2 + n * 25 * d / (64 * 16384);
    return (int'(on) >= ex - 8) && (int'(on) <= ex + 8);
  endfunction
  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // settle, then count over 4096 driven and 1024 external bits
  task automatic dens(input int d);
    pos = 16'(d / 2);
    neg = 16'(d / 2 - d);
    repeat (64) @(negedge clk);
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
    repeat (8192) @(negedge clk);
    `CHK(bt_i, 16'd4096)
    `CHK(near(on_i, 4096, d), 1'b1)
    `CHK(bt_e, 16'd1024)
    `CHK(near(on_e, 1024, d), 1'b1)
  endtask
  ////////////////////////////////////////
  initial
  begin
    repeat (6) @(negedge clk);
    `CHK(oe_i, 1'b0)
    rst = 1'b0;
    run = 1'b1;
    while (oe_i !== 1'b1 && w < 10)
    begin
      @(negedge clk);
      w++;
    end
    if (w == 10)
    begin
      num_errors++;
      end_sim();
    end
    `CHK(oe_e, 1'b0)
    `CHK(mck_e, 1'b0)
    `CHK(dat_i, 1'b1)
    // full, half and zero scale, then random levels
    foreach (lv[k])
      dens(lv[k]);
    repeat (3)
    begin
      r = lfsr(r);
      dens(int'(r % 32'd32769) - 16384);
    end
    // supply loss, run-out of the driven clock, return
    sup = 1'b0;
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
    repeat (700) @(negedge clk);
    `CHK(dat_i, 1'b1)
    `CHK(dat_e, 1'b0)
    `CHK(mck_i, 1'b1)
    `CHK(bt_i >= 16'd256 && bt_i <= 16'd258, 1'b1)
    sup = 1'b1;
    repeat (10) @(negedge clk);
    `CHK(dat_i, 1'b1)
    `CHK(dat_e, 1'b0)
    dens(16384);
    end_sim();
  end
endmodule
